/* spmc_ctrl.sv */
// Serial pipe mode controller: decides whether the host UART carries
// commands and events or is a transparent data pipe to a remote peer.
// Assumes pin inputs are resolved levels synchronous to core_clk_i,
// an undriven pin reading as the level of its pull.
`timescale 1ns/1ns

// Behaviour
// RL1 - Disabled and pin not low: pipe inactive, attributes hidden; the code only holds an idle pipe idle, an active pipe stays active.
// RL2 - Enabled: idle until start command, then advertise or scan.
// RL3 - Pin floating: events until data opens, then pull pin low.
// RL4 - Data mode ends on peer disconnect or unsubscribe; the code has no unsubscribe input and ends it on peer_drop_i only.
// RL5 - Autostart: start at boot and restart after each disconnect.
// RL6 - Pin held high: commands stay alive, never transparent data.
// RL7 - Autostart with pin high: events continue, auto starts still apply.
// RL8 - Pin driven low: pipe active regardless, starts at boot.
// RL9 - Pin low: all command and event traffic suppressed.
// RL10 - Role pin pulled to configured role; pin level decides role.
// RL11 - Pins sampled continuously so overrides act at once.
module spmc_ctrl
    import spmc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
)
(
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    // Pipe control pin, open drain, active low
    input wire logic pipe_pin_i,
    output logic pipe_pin_o,
    output logic pipe_pin_oe_o,
    // Role select pin, pulled toward the configured role
    input wire logic role_select_pin_i,
    output logic role_select_pin_o,
    output logic role_select_pin_oe_o,
    // Link events from the radio side
    input wire logic peer_open_i,
    input wire logic peer_drop_i,
    // Radio requests and UART gating
    output logic adv_o,
    output logic scan_o,
    output logic gatt_vis_o,
    output spmc_uart_t uart_o,
    // Interrupt
    output logic irq_o
);
    initial
    begin
        if (ADDR_W < 5 || ADDR_W > 8)
            $error("spmc_ctrl: ADDR_W must be 5 to 8");
        if (DATA_W < 8)
            $error("spmc_ctrl: DATA_W must be at least 8");
    end

    // Address match against a byte offset
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off[ADDR_W-1:0]);
    endfunction

    spmc_ctrl_t ctrl;
    spmc_state_t state;
    spmc_state_t next_state;
    logic booted;
    logic pin_low;
    logic ext_low;
    logic ext_low_q;
    logic role;
    logic start_cmd;
    logic auto_on;
    logic start_ok;
    logic ctrl_wr;
    logic clr_wr;
    logic mask_wr;
    logic ovrd;
    logic ovrd_q;
    logic [SPMC_EV_NUM-1:0] ev_set;
    logic [SPMC_EV_NUM-1:0] ist;
    logic [SPMC_EV_NUM-1:0] imask;
    logic [DATA_W-1:0] next_rdata;

    // Write decode
    assign ctrl_wr = reg_wr_i && hit(reg_addr_i, SPMC_OFF_CTRL);
    assign clr_wr = reg_wr_i && hit(reg_addr_i, SPMC_OFF_ISTAT);
    assign mask_wr = reg_wr_i && hit(reg_addr_i, SPMC_OFF_IMASK);
    assign start_cmd = reg_wr_i && hit(reg_addr_i, SPMC_OFF_CMD)
        && reg_wdata_i[SPMC_CMD_START_BIT];

    // Pin levels used directly, no filter, so overrides act at once
    assign pin_low = !pipe_pin_i; // RL11
    assign role = role_select_pin_i; // RL10 RL11

    // Pipe settings, the set-parameters command
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ctrl <= SPMC_CTRL_RST;
        else if (ce_i && ctrl_wr)
        begin
            ctrl.mode <= spmc_mode_t'(
                reg_wdata_i[SPMC_CTRL_MODE_LSB +: $bits(spmc_mode_t)]);
            ctrl.role <= reg_wdata_i[SPMC_CTRL_ROLE_BIT];
        end
    end

    // Boot marker: first enabled cycle after reset counts as boot
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            booted <= 1'b0;
        else if (ce_i)
            booted <= 1'b1;
    end

    // Host drive on the pipe pin, seen only while our own pull is off.
    // In data mode the pull masks it, so the level held on entry stands;
    // a host letting go during data mode is seen once data mode ends.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ext_low_q <= 1'b0;
        else if (ce_i && !pipe_pin_oe_o)
            ext_low_q <= pin_low;
    end
    // Own pull must not count as an override, else enabled would restart
    assign ext_low = pipe_pin_oe_o ? ext_low_q : pin_low; // RL8

    // Automatic operation: autostart setting or pin forced low
    assign auto_on = ctrl.mode == SPMC_MODE_AUTO || ext_low; // RL5 RL8
    // Start command only counts when the profile is enabled
    assign start_ok = start_cmd && ctrl.mode != SPMC_MODE_DIS; // RL2

    // Next state of the pipe
    always_comb
    begin
        next_state = state;
        unique case (state)
            SPMC_ST_IDLE:
            begin
                // Disabled with pin high never leaves idle
                if (start_ok || (auto_on && !booted) || ext_low)
                    next_state = SPMC_ST_ACTIVE; // RL1 RL2 RL5 RL8
            end
            SPMC_ST_ACTIVE:
            begin
                if (peer_open_i)
                    next_state = SPMC_ST_DATA; // RL3
            end
            SPMC_ST_DATA:
            begin
                // Restart after disconnect only when automatic
                if (peer_drop_i)
                    next_state = auto_on ? SPMC_ST_ACTIVE
                        : SPMC_ST_IDLE; // RL4 RL5 RL7
            end
            default:
                next_state = SPMC_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state <= SPMC_ST_IDLE;
        else if (ce_i)
            state <= next_state;
    end

    // Pull the pipe pin low while the data connection is open
    assign pipe_pin_o = 1'b0;
    assign pipe_pin_oe_o = state == SPMC_ST_DATA; // RL3

    // Pull the role pin to the configured role; a stronger drive wins
    assign role_select_pin_o = ctrl.role; // RL10
    assign role_select_pin_oe_o = 1'b1;

    // Radio requests follow the pin-defined role
    assign adv_o = state == SPMC_ST_ACTIVE
        && role == SPMC_ROLE_PERIPH; // RL2 RL10
    assign scan_o = state == SPMC_ST_ACTIVE
        && role != SPMC_ROLE_PERIPH; // RL2 RL10

    // Pipe attributes hidden whenever disabled with the pin not low, in any pipe state
    assign gatt_vis_o = ctrl.mode != SPMC_MODE_DIS || pin_low; // RL1

    // UART gating hangs on the pin, so a host holding it high keeps
    // commands even while data connection exists
    assign uart_o.cmd_en = !pin_low; // RL4 RL6 RL9
    assign uart_o.evt_en = !pin_low; // RL7 RL9
    assign uart_o.data_mode = pin_low
        && state == SPMC_ST_DATA; // RL3 RL6

    // Role override seen on the pin, for the override event
    assign ovrd = role != ctrl.role;
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ovrd_q <= 1'b0;
        else if (ce_i)
            ovrd_q <= ovrd;
    end

    // Events feeding sticky flags
    always_comb
    begin
        ev_set = '0;
        ev_set[SPMC_EV_OPEN] = state == SPMC_ST_ACTIVE
            && next_state == SPMC_ST_DATA;
        ev_set[SPMC_EV_CLOSE] = state == SPMC_ST_DATA
            && next_state != SPMC_ST_DATA;
        ev_set[SPMC_EV_OVRD] = ovrd && !ovrd_q;
    end

    spmc_irq #(
        .N(SPMC_EV_NUM)
    ) i_spmc_irq (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .set_i(ev_set),
        .clr_wr_i(clr_wr),
        .mask_wr_i(mask_wr),
        .wdata_i(reg_wdata_i[SPMC_EV_NUM-1:0]),
        .status_o(ist),
        .mask_o(imask),
        .irq_o(irq_o)
    );

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        next_rdata = '0;
        if (hit(reg_addr_i, SPMC_OFF_CTRL))
            next_rdata = DATA_W'({ctrl.role, ctrl.mode});
        else if (hit(reg_addr_i, SPMC_OFF_STAT))
            next_rdata = DATA_W'({uart_o.data_mode, role, pin_low,
                                  state});
        else if (hit(reg_addr_i, SPMC_OFF_ISTAT))
            next_rdata = DATA_W'(ist);
        else if (hit(reg_addr_i, SPMC_OFF_IMASK))
            next_rdata = DATA_W'(imask);
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            reg_rdata_o <= '0;
        else if (ce_i)
            reg_rdata_o <= reg_rd_i ? next_rdata : '0;
    end

    // Checks
    AST_DIS_IDLE: assert property (@(posedge core_clk_i) // RL1
        disable iff (!resetn_i)
        ctrl.mode == SPMC_MODE_DIS && !pin_low && booted
        && state == SPMC_ST_IDLE |=> state == SPMC_ST_IDLE)
        else $error("disabled pipe left idle");

    AST_DIS_HIDE: assert property (@(posedge core_clk_i) // RL1
        disable iff (!resetn_i)
        state == SPMC_ST_IDLE && ctrl.mode == SPMC_MODE_DIS
        && !pin_low |-> !gatt_vis_o && !adv_o && !scan_o)
        else $error("disabled pipe visible or active");

    AST_EN_START: assert property (@(posedge core_clk_i) // RL2
        disable iff (!resetn_i)
        ce_i && state == SPMC_ST_IDLE && ctrl.mode == SPMC_MODE_EN
        && start_cmd |=> state == SPMC_ST_ACTIVE && (adv_o || scan_o))
        else $error("start command did not start pipe");

    AST_EN_WAIT: assert property (@(posedge core_clk_i) // RL2
        disable iff (!resetn_i)
        booted && state == SPMC_ST_IDLE && ctrl.mode == SPMC_MODE_EN
        && !start_cmd && !pin_low |=> state == SPMC_ST_IDLE)
        else $error("enabled pipe started without command");

    AST_OPEN_PULL: assert property (@(posedge core_clk_i) // RL3
        disable iff (!resetn_i)
        ce_i && state == SPMC_ST_ACTIVE && peer_open_i
        |=> pipe_pin_oe_o && !pipe_pin_o)
        else $error("pipe pin not pulled low on open");

    AST_DROP: assert property (@(posedge core_clk_i) // RL4
        disable iff (!resetn_i)
        ce_i && state == SPMC_ST_DATA && peer_drop_i
        |=> !pipe_pin_oe_o && !uart_o.data_mode)
        else $error("data mode kept after drop");

    AST_AUTO_RESTART: assert property (@(posedge core_clk_i) // RL5
        disable iff (!resetn_i)
        ce_i && state == SPMC_ST_DATA && peer_drop_i
        && ctrl.mode == SPMC_MODE_AUTO |=> state == SPMC_ST_ACTIVE)
        else $error("autostart did not restart");

    AST_EN_DROP: assert property (@(posedge core_clk_i) // RL4
        disable iff (!resetn_i)
        ce_i && state == SPMC_ST_DATA && peer_drop_i
        && ctrl.mode == SPMC_MODE_EN && !ext_low_q
        |=> state == SPMC_ST_IDLE)
        else $error("enabled pipe restarted after drop");

    AST_BOOT_START: assert property (@(posedge core_clk_i) // RL8
        disable iff (!resetn_i)
        ce_i && !booted && (ctrl.mode == SPMC_MODE_AUTO || pin_low)
        |=> state == SPMC_ST_ACTIVE)
        else $error("no automatic start at boot");

    AST_PIN_HIGH: assert property (@(posedge core_clk_i) // RL6
        disable iff (!resetn_i)
        pipe_pin_i |-> uart_o.cmd_en && uart_o.evt_en
        && !uart_o.data_mode)
        else $error("commands lost with pin high");

    AST_PIN_LOW: assert property (@(posedge core_clk_i) // RL9
        disable iff (!resetn_i)
        !pipe_pin_i |-> !uart_o.cmd_en && !uart_o.evt_en)
        else $error("traffic not suppressed with pin low");

    AST_ROLE: assert property (@(posedge core_clk_i) // RL10
        disable iff (!resetn_i)
        state == SPMC_ST_ACTIVE |-> scan_o == role_select_pin_i
        && adv_o == !role_select_pin_i
        && role_select_pin_o == ctrl.role)
        else $error("role does not follow pin");

    CVR_DATA: cover property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        state == SPMC_ST_ACTIVE ##1 state == SPMC_ST_DATA);

    CVR_RESTART: cover property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        state == SPMC_ST_DATA ##1 state == SPMC_ST_ACTIVE);

    CVR_OVERRIDE: cover property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        ctrl.mode == SPMC_MODE_DIS && pin_low
        && state == SPMC_ST_ACTIVE);

endmodule // spmc_ctrl

/* spmc_pkg.sv */
// Package for the serial pipe mode controller: register map, field
// layout, reset values, mode and state encodings, shared structs.
// Assumes a single 250 MHz core clock domain.
package spmc_pkg;

    // Register byte offsets on the plain register port
    localparam logic [7:0] SPMC_OFF_CTRL = 8'h00;
    localparam logic [7:0] SPMC_OFF_CMD = 8'h04;
    localparam logic [7:0] SPMC_OFF_STAT = 8'h08;
    localparam logic [7:0] SPMC_OFF_ISTAT = 8'h0C;
    localparam logic [7:0] SPMC_OFF_IMASK = 8'h10;

    // Control register field positions
    localparam int SPMC_CTRL_MODE_LSB = 0;
    localparam int SPMC_CTRL_ROLE_BIT = 2;
    // Command register: start strobe bit
    localparam int SPMC_CMD_START_BIT = 0;

    // Interrupt event bit positions
    localparam int SPMC_EV_OPEN = 0;
    localparam int SPMC_EV_CLOSE = 1;
    localparam int SPMC_EV_OVRD = 2;
    localparam int SPMC_EV_NUM = 3;

    // Profile enable setting
    typedef enum logic [1:0] {
        SPMC_MODE_DIS = 2'h0,
        SPMC_MODE_EN = 2'h1,
        SPMC_MODE_AUTO = 2'h2
    } spmc_mode_t;

    // Role: low is peripheral (advertise), high is central (scan)
    localparam logic SPMC_ROLE_PERIPH = 1'b0;

    // Pipe state, Gray coded along idle -> active -> data
    typedef enum logic [1:0] {
        SPMC_ST_IDLE = 2'h0,
        SPMC_ST_ACTIVE = 2'h1,
        SPMC_ST_DATA = 2'h3
    } spmc_state_t;

    // Settings written by software
    typedef struct packed {
        logic role;
        spmc_mode_t mode;
    } spmc_ctrl_t;

    // Factory default: autostart, peripheral role
    localparam spmc_ctrl_t SPMC_CTRL_RST = '{
        role: SPMC_ROLE_PERIPH, mode: SPMC_MODE_AUTO};

    // Gating of the host UART
    typedef struct packed {
        logic cmd_en;
        logic evt_en;
        logic data_mode;
    } spmc_uart_t;

endpackage

/* spmc_irq.sv */
// Sticky event flags with write-one-to-clear, mask and level interrupt.
// Assumes event pulses and register writes on the same clock.
`timescale 1ns/1ns
module spmc_irq
    import spmc_pkg::*;
#(
    parameter int N = SPMC_EV_NUM
)
(
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Events and software access
    input wire logic [N-1:0] set_i,
    input wire logic clr_wr_i,
    input wire logic mask_wr_i,
    input wire logic [N-1:0] wdata_i,
    // State and interrupt
    output logic [N-1:0] status_o,
    output logic [N-1:0] mask_o,
    output logic irq_o
);
    initial
    begin
        if (N < 1)
            $error("spmc_irq: N must be at least one");
    end

    // Set wins over a clear in the same cycle, so no event is lost
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            status_o <= '0;
        else if (ce_i)
            status_o <= (status_o & ~(clr_wr_i ? wdata_i : '0)) | set_i;
    end

    // Mask register, one bit enables one event
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            mask_o <= '0;
        else if (ce_i && mask_wr_i)
            mask_o <= wdata_i;
    end

    assign irq_o = |(status_o & mask_o);

    AST_IRQ_STICKY: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        ce_i && |set_i |=> (status_o & $past(set_i)) == $past(set_i))
        else $error("event flag not set");

endmodule // spmc_irq

/* spmc_host_model.sv */
// Host side of the pipe controller: resolves the pipe and role pins.
// Assumes the bench sets the host drive controls by non-blocking writes.
`timescale 1ns/1ns
module spmc_host_model
    import spmc_pkg::*;
(
    // Host drive controls: pipe 0 float, 1 high, 2 low
    input wire logic [1:0] pipe_drv_i,
    input wire logic role_drv_i,
    input wire logic role_val_i,
    // Device pin outputs
    input wire logic dev_pipe_i,
    input wire logic dev_pipe_oe_i,
    input wire logic dev_role_i,
    input wire logic dev_role_oe_i,
    // Resolved pin levels
    output logic pipe_lvl_o,
    output logic role_lvl_o
);
    // Host drive beats the device pull; floating pin sits on the pull-up
    assign pipe_lvl_o = (pipe_drv_i == 2'h2) ? 1'h0 :
        (pipe_drv_i == 2'h1) ? 1'h1 :
        (dev_pipe_oe_i ? dev_pipe_i : 1'h1);
    // External role drive wins over the device's weak pull
    assign role_lvl_o = role_drv_i ? role_val_i :
        (dev_role_oe_i ? dev_role_i : ~dev_role_i);
endmodule // spmc_host_model

/* test_serial_pipe_mode_control.sv */
// Self-checking bench for the serial pipe mode controller.
// Assumes a host model resolving both pins and one 250 MHz clock.
`timescale 1ns/1ns
module test_serial_pipe_mode_control
    import spmc_pkg::*;
();
    logic core_clk = 1'h0;
    logic ce = 1'h1;
    logic resetn = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] rdata;
    logic peer_open = 1'h0;
    logic peer_drop = 1'h0;
    logic [1:0] pipe_drv = 2'h0;
    logic role_drv = 1'h0;
    logic role_val = 1'h0;
    logic pipe_lvl, role_lvl, pipe_o, pipe_oe, role_o, role_oe;
    logic adv, scan, gvis, irq;
    spmc_uart_t uart;
    int err_total = 0;
    int num_checks = 0;

    spmc_ctrl i_spmc_ctrl (
        .core_clk_i(core_clk), .resetn_i(resetn), .ce_i(ce),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .pipe_pin_i(pipe_lvl), .pipe_pin_o(pipe_o),
        .pipe_pin_oe_o(pipe_oe), .role_select_pin_i(role_lvl),
        .role_select_pin_o(role_o), .role_select_pin_oe_o(role_oe),
        .peer_open_i(peer_open), .peer_drop_i(peer_drop),
        .adv_o(adv), .scan_o(scan), .gatt_vis_o(gvis),
        .uart_o(uart), .irq_o(irq));

    spmc_host_model i_spmc_host_model (
        .pipe_drv_i(pipe_drv), .role_drv_i(role_drv),
        .role_val_i(role_val), .dev_pipe_i(pipe_o),
        .dev_pipe_oe_i(pipe_oe), .dev_role_i(role_o),
        .dev_role_oe_i(role_oe), .pipe_lvl_o(pipe_lvl),
        .role_lvl_o(role_lvl));

    // Core clock, 4 ns period
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Register bus cycles: strobe held for exactly one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdc(input string what, input logic [7:0] a,
        input logic [31:0] m, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        chk(what, exp, rdata & m);
    endtask

    // One-cycle link event: drop when set, else open
    task automatic pulse(input bit drop);
        @(posedge core_clk);
        if (drop)
            peer_drop <= 1'h1;
        else
            peer_open <= 1'h1;
        @(posedge core_clk);
        peer_drop <= 1'h0;
        peer_open <= 1'h0;
        #1;
    endtask

    task automatic host(input logic [1:0] p, input logic d, input logic v);
        @(posedge core_clk);
        pipe_drv <= p;
        role_drv <= d;
        role_val <= v;
        #1;
    endtask

    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask

    task automatic t_boot;
        rdc("ctrl", SPMC_OFF_CTRL, 32'hFFFF_FFFF, 32'(SPMC_CTRL_RST));
        rdc("state", SPMC_OFF_STAT, 32'h0000_0003, 32'(SPMC_ST_ACTIVE));
        chk("adv", 1'h1, adv);
        chk("scan", 1'h0, scan);
        chk("role_oe", 1'h1, role_oe);
        chk("cmd_en", 1'h1, uart.cmd_en);
        chk("gvis", 1'h1, gvis);
        rdc("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
        $display("t_boot done");
    endtask

    task automatic t_auto_data;
        wr(SPMC_OFF_IMASK, 32'h0000_0007);
        pulse(1'b0);
        chk("pin_oe", 1'h1, pipe_oe);
        chk("pin", 1'h0, pipe_lvl);
        chk("cmd_en", 1'h0, uart.cmd_en);
        chk("evt_en", 1'h0, uart.evt_en);
        chk("data", 1'h1, uart.data_mode);
        chk("irq", 1'h1, irq);
        pulse(1'b1);
        chk("pin_oe", 1'h0, pipe_oe);
        chk("cmd_en", 1'h1, uart.cmd_en);
        chk("adv", 1'h1, adv);
        rdc("istat", SPMC_OFF_ISTAT, 32'h0000_0007, 32'h0000_0003);
        wr(SPMC_OFF_ISTAT, 32'h0000_0003);
        chk("irq", 1'h0, irq);
        $display("t_auto_data done");
    endtask

    task automatic t_role;
        chk("role_o", 1'h0, role_o);
        host(2'h0, 1'h1, 1'h1);
        chk("scan", 1'h1, scan);
        chk("adv", 1'h0, adv);
        tick();
        rdc("istat", SPMC_OFF_ISTAT, 32'h0000_0004, 32'h0000_0004);
        chk("irq", 1'h1, irq);
        host(2'h0, 1'h0, 1'h0);
        wr(SPMC_OFF_CTRL, 32'h0000_0006);
        chk("role_o", 1'h1, role_o);
        chk("scan", 1'h1, scan);
        wr(SPMC_OFF_ISTAT, 32'h0000_0007);
        chk("irq", 1'h0, irq);
        $display("t_role done");
    endtask

    task automatic t_enabled;
        wr(SPMC_OFF_CTRL, 32'h0000_0001);
        pulse(1'b0);
        pulse(1'b1);
        chk("adv", 1'h0, adv);
        rdc("state", SPMC_OFF_STAT, 32'h0000_0003, 32'(SPMC_ST_IDLE));
        wr(SPMC_OFF_CMD, 32'h0000_0001);
        chk("adv", 1'h1, adv);
        wr(SPMC_OFF_ISTAT, 32'h0000_0007);
        $display("t_enabled done");
    endtask

    task automatic t_pin_high;
        host(2'h1, 1'h0, 1'h0);
        pulse(1'b0);
        rdc("state", SPMC_OFF_STAT, 32'h0000_0003, 32'(SPMC_ST_DATA));
        chk("cmd_en", 1'h1, uart.cmd_en);
        chk("data", 1'h0, uart.data_mode);
        pulse(1'b1);
        rdc("state", SPMC_OFF_STAT, 32'h0000_0003, 32'(SPMC_ST_IDLE));
        host(2'h0, 1'h0, 1'h0);
        wr(SPMC_OFF_ISTAT, 32'h0000_0007);
        $display("t_pin_high done");
    endtask

    task automatic t_disabled;
        wr(SPMC_OFF_CTRL, 32'h0000_0000);
        wr(SPMC_OFF_CMD, 32'h0000_0001);
        rdc("state", SPMC_OFF_STAT, 32'h0000_0003, 32'(SPMC_ST_IDLE));
        chk("adv", 1'h0, adv);
        chk("scan", 1'h0, scan);
        chk("gvis", 1'h0, gvis);
        chk("cmd_en", 1'h1, uart.cmd_en);
        $display("t_disabled done");
    endtask

    task automatic t_pin_low;
        host(2'h2, 1'h0, 1'h0);
        chk("cmd_en", 1'h0, uart.cmd_en);
        chk("evt_en", 1'h0, uart.evt_en);
        chk("gvis", 1'h1, gvis);
        tick();
        chk("adv", 1'h1, adv);
        pulse(1'b0);
        chk("data", 1'h1, uart.data_mode);
        pulse(1'b1);
        chk("adv", 1'h1, adv);
        host(2'h0, 1'h0, 1'h0);
        $display("t_pin_low done");
    endtask

    // Enable low: an open event must leave the state untouched
    task automatic t_freeze;
        @(posedge core_clk);
        ce <= 1'h0;
        pulse(1'b0);
        chk("frozen_oe", 1'h0, pipe_oe);
        chk("frozen_adv", 1'h1, adv);
        @(posedge core_clk);
        ce <= 1'h1;
        #1;
        $display("t_freeze done");
    endtask

    // Main sequence: reset, then the scenarios in order
    initial
    begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'h1;
        t_boot();
        t_auto_data();
        t_role();
        t_enabled();
        t_pin_high();
        t_disabled();
        t_pin_low();
        t_freeze();
        final_report();
    end

    // Hang guard, far beyond the roughly 80 cycles the run needs
    initial
    begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        $display("watchdog expired");
        final_report();
    end
endmodule // test_serial_pipe_mode_control
